/* File: hdl/lpp_pkg.sv */
// lpp_pkg: object indices, frame layout, reset values and timing
// assumes one 10 MHz system clock and CAN frames handed over as structs
package lpp_pkg;

  // object dictionary indices
  localparam logic [15:0] IDX_OPPAR   = 16'h6000;
  localparam logic [15:0] IDX_RANGE_A = 16'h6001;
  localparam logic [15:0] IDX_RANGE   = 16'h6002;
  localparam logic [15:0] IDX_PRESET  = 16'h6003;
  localparam logic [15:0] IDX_POS     = 16'h6004;
  localparam logic [15:0] IDX_CYCLE   = 16'h6200;
  localparam logic [15:0] IDX_OFFSET  = 16'h6509;
  localparam logic [7:0]  SUB_ZERO    = 8'h00;

  // reset values and limits
  localparam logic [31:0] RANGE_RST   = 32'h0002_0000;
  localparam logic [31:0] RANGE_MIN   = 32'h0000_0001;
  localparam logic [31:0] PRESET_RST  = 32'h0000_0000;
  localparam logic [31:0] OFFSET_RST  = 32'h0000_0000;
  localparam logic [15:0] OPPAR_RST   = 16'h0000;
  localparam logic [15:0] CYCLE_RST   = 16'h0000;
  localparam int          SCALE_BIT   = 2;

  // identifiers and command bytes
  localparam logic [10:0] COB_SDO_RX  = 11'h600;
  localparam logic [10:0] COB_SDO_TX  = 11'h580;
  localparam logic [10:0] COB_TPDO1   = 11'h180;
  localparam logic [10:0] COB_SYNC    = 11'h080;
  localparam logic [7:0]  CMD_DL4     = 8'h23;
  localparam logic [7:0]  CMD_DL_ACK  = 8'h60;
  localparam logic [7:0]  CMD_UL_REQ  = 8'h40;
  localparam logic [7:0]  CMD_UL4     = 8'h43;
  localparam logic [7:0]  CMD_ABORT   = 8'h80;
  localparam logic [3:0]  DLC_SDO     = 4'h8;
  localparam logic [3:0]  DLC_PDO     = 4'h4;

  // abort codes
  localparam logic [31:0] AB_NONE     = 32'h0000_0000;
  localparam logic [31:0] AB_CMD      = 32'h0504_0001;
  localparam logic [31:0] AB_RO       = 32'h0601_0002;
  localparam logic [31:0] AB_NO_OBJ   = 32'h0602_0000;
  localparam logic [31:0] AB_SUB      = 32'h0609_0011;
  localparam logic [31:0] AB_VALUE    = 32'h0609_0030;
  localparam logic [31:0] AB_STATE    = 32'h0800_0022;

  // timing
  localparam int          PERIOD_NS   = 100;
  localparam int          MS_NS       = 1000000;
  localparam int          CYC_PER_MS  = MS_NS / PERIOD_NS;

  typedef struct packed {
    logic [10:0] id;
    logic [3:0]  dlc;
    logic [63:0] data;
  } lpp_frame_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SDO  = 2'b01,
    TX_PDO  = 2'b11
  } lpp_tx_state_t;

endpackage

/* File: hdl/lpp_pos_fold.sv */
// lpp_pos_fold: transmitted position, modulo the active range
// assumes read position, preset and offset each below the range
`timescale 1ns/100ps
module lpp_pos_fold (
  // clock, reset, enable
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        ce,
  // operands
  input  wire logic [31:0] read_pos,
  input  wire logic [31:0] preset,
  input  wire logic [31:0] offset,
  input  wire logic [31:0] range_eff,
  // results
  output logic      [31:0] read_folded,
  output logic      [31:0] tx_pos
);

  logic [32:0] sum;
  logic [32:0] sum_fold;
  logic [32:0] diff;
  logic [31:0] next_tx_pos;

  // read position kept inside the range
  assign read_folded = (read_pos >= range_eff) ? read_pos - range_eff
                                               : read_pos;
  assign sum      = {1'b0, read_folded} + {1'b0, preset};
  assign sum_fold = (sum >= {1'b0, range_eff}) ? sum - {1'b0, range_eff}
                                               : sum;
  // backwards through zero wraps to range minus one
  assign diff = (sum_fold < {1'b0, offset})
              ? sum_fold + {1'b0, range_eff} - {1'b0, offset}
              : sum_fold - {1'b0, offset};
  assign next_tx_pos = diff[31:0];

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      tx_pos <= lpp_pkg::PRESET_RST;
    end else if (ce) begin
      tx_pos <= next_tx_pos;
    end
  end

  a_fold_bound: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    ce && read_pos < range_eff && preset < range_eff
      && offset < range_eff |=> tx_pos < $past(range_eff))
    else $error("transmitted position outside range");

  a_fold_value: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    ce && read_pos < range_eff && read_pos + preset < range_eff
      && read_pos + preset >= offset
      |=> tx_pos == $past(read_pos) + $past(preset) - $past(offset))
    else $error("transmitted position not read plus preset minus offset");

endmodule

/* File: hdl/lpp_position_node.sv */
// lpp_position_node: position objects, preset and position PDO
// assumes a CAN controller on clk_sys passing whole frames by valid/ready
`timescale 1ns/100ps
module lpp_position_node #(
  parameter int unsigned CYC_PER_MS = lpp_pkg::CYC_PER_MS
) (
  // clock, reset, enable
  input  wire logic               clk_sys,
  input  wire logic               resetn,
  input  wire logic               ce,
  // straps and sensor, asynchronous
  input  wire logic [6:0]         node_id,
  input  wire logic [31:0]        raw_pos,
  // received frames
  input  wire lpp_pkg::lpp_frame_t rx_frame,
  input  wire logic               rx_valid,
  output logic                    rx_ready,
  // transmitted frames
  output lpp_pkg::lpp_frame_t     tx_frame,
  output logic                    tx_valid,
  input  wire logic               tx_ready,
  // status
  output logic                    scaling_on,
  output logic [31:0]             position
);

  localparam int MSW = $clog2(CYC_PER_MS + 1);

  ////////////////////////////////////////////////////////////////////////
  // synchronisers

  logic [6:0]  id_s1;
  logic [6:0]  id_s2;
  logic [31:0] pos_s1;
  logic [31:0] pos_s2;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      id_s1  <= 7'h00;
      id_s2  <= 7'h00;
      pos_s1 <= 32'h0000_0000;
      pos_s2 <= 32'h0000_0000;
    end else if (ce) begin
      id_s1  <= node_id;
      id_s2  <= id_s1;
      pos_s1 <= raw_pos;
      pos_s2 <= pos_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // objects

  logic [15:0]            oppar;
  logic [31:0]            range_reg;
  logic [31:0]            preset;
  logic [31:0]            offset;
  logic [15:0]            cycle_ms;
  logic [31:0]            range_eff;
  logic [31:0]            read_folded;
  lpp_pkg::lpp_tx_state_t state;

  assign scaling_on = oppar[lpp_pkg::SCALE_BIT];
  // physical range while scaling is off
  assign range_eff  = scaling_on ? range_reg : lpp_pkg::RANGE_RST;

  lpp_pos_fold u_fold (
    .clk_sys     (clk_sys),
    .resetn      (resetn),
    .ce          (ce),
    .read_pos    (pos_s2),
    .preset      (preset),
    .offset      (offset),
    .range_eff   (range_eff),
    .read_folded (read_folded),
    .tx_pos      (position)
  );

  ////////////////////////////////////////////////////////////////////////
  // request decode

  logic [7:0]  rx_cmd;
  logic [15:0] rx_idx;
  logic [7:0]  rx_sub;
  logic [31:0] rx_val;
  logic        rx_take;
  logic        is_sdo;
  logic        is_sync;
  logic        is_dl;
  logic        is_ul;
  logic        is_range;
  logic        known;
  logic        read_only;
  logic [31:0] abort_code;
  logic        wr_ok;
  logic [31:0] rd_val;

  assign rx_cmd   = rx_frame.data[7:0];
  assign rx_idx   = rx_frame.data[23:8];
  assign rx_sub   = rx_frame.data[31:24];
  assign rx_val   = rx_frame.data[63:32];
  assign rx_ready = (state == lpp_pkg::TX_IDLE);
  assign rx_take  = ce && rx_valid && rx_ready;
  assign is_sdo   = rx_frame.id == lpp_pkg::COB_SDO_RX + {4'h0, id_s2};
  assign is_sync  = rx_frame.id == lpp_pkg::COB_SYNC;
  assign is_dl    = rx_cmd == lpp_pkg::CMD_DL4;
  assign is_ul    = rx_cmd == lpp_pkg::CMD_UL_REQ;
  assign is_range = rx_idx == lpp_pkg::IDX_RANGE_A
                 || rx_idx == lpp_pkg::IDX_RANGE;
  assign read_only = rx_idx == lpp_pkg::IDX_POS
                  || rx_idx == lpp_pkg::IDX_OFFSET;
  assign known    = is_range || read_only
                 || rx_idx == lpp_pkg::IDX_OPPAR
                 || rx_idx == lpp_pkg::IDX_PRESET
                 || rx_idx == lpp_pkg::IDX_CYCLE;

  assign abort_code =
      !(is_dl || is_ul)               ? lpp_pkg::AB_CMD    :
      !known                          ? lpp_pkg::AB_NO_OBJ :
      rx_sub != lpp_pkg::SUB_ZERO     ? lpp_pkg::AB_SUB    :
      (is_dl && read_only)            ? lpp_pkg::AB_RO     :
      (is_dl && is_range && !scaling_on) ? lpp_pkg::AB_STATE :
      (is_dl && is_range && (rx_val < lpp_pkg::RANGE_MIN
        || rx_val > lpp_pkg::RANGE_RST)) ? lpp_pkg::AB_VALUE :
                                        lpp_pkg::AB_NONE;

  assign wr_ok = rx_take && is_sdo && is_dl
              && abort_code == lpp_pkg::AB_NONE;

  assign rd_val =
      rx_idx == lpp_pkg::IDX_OPPAR  ? {16'h0000, oppar}    :
      is_range                      ? range_reg            :
      rx_idx == lpp_pkg::IDX_PRESET ? preset               :
      rx_idx == lpp_pkg::IDX_POS    ? position             :
      rx_idx == lpp_pkg::IDX_CYCLE  ? {16'h0000, cycle_ms} :
                                      offset;

  ////////////////////////////////////////////////////////////////////////
  // object writes

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      oppar     <= lpp_pkg::OPPAR_RST;
      range_reg <= lpp_pkg::RANGE_RST;
      preset    <= lpp_pkg::PRESET_RST;
      offset    <= lpp_pkg::OFFSET_RST;
      cycle_ms  <= lpp_pkg::CYCLE_RST;
    end else if (wr_ok) begin
      if (rx_idx == lpp_pkg::IDX_OPPAR) begin
        oppar <= rx_val[15:0];
      end else if (is_range) begin
        range_reg <= rx_val;
      end else if (rx_idx == lpp_pkg::IDX_PRESET) begin
        preset <= rx_val;
        offset <= read_folded;
      end else if (rx_idx == lpp_pkg::IDX_CYCLE) begin
        cycle_ms <= rx_val[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pdo trigger: cyclic timer, or sync when the cycle time is zero

  logic [MSW-1:0] ms_cnt;
  logic [15:0]    ms_elapsed;
  logic           ms_tick;
  logic           cyc_due;
  logic           sync_due;
  logic           pdo_load;
  logic           pdo_pend;

  assign ms_tick  = ms_cnt == MSW'(CYC_PER_MS - 1);
  assign cyc_due  = ms_tick && cycle_ms != 16'h0000
                 && ms_elapsed + 16'h0001 >= cycle_ms;
  assign sync_due = rx_take && is_sync && cycle_ms == 16'h0000;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ms_cnt     <= '0;
      ms_elapsed <= 16'h0000;
    end else if (ce) begin
      ms_cnt     <= ms_tick ? '0 : ms_cnt + MSW'(1);
      if (cycle_ms == 16'h0000 || cyc_due) begin
        ms_elapsed <= 16'h0000;
      end else if (ms_tick) begin
        ms_elapsed <= ms_elapsed + 16'h0001;
      end
    end
  end

  // a new trigger wins over the clear by loading
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pdo_pend <= 1'b0;
    end else if (ce) begin
      pdo_pend <= cyc_due || sync_due || (pdo_pend && !pdo_load);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit: sdo answer first, then pending position pdo

  logic        sdo_load;
  lpp_pkg::lpp_frame_t sdo_frame;
  lpp_pkg::lpp_frame_t pdo_frame;
  logic [7:0]  resp_cmd;
  logic [31:0] resp_val;

  assign sdo_load = rx_take && is_sdo;
  assign pdo_load = ce && state == lpp_pkg::TX_IDLE && !sdo_load
                 && pdo_pend;
  assign resp_cmd = abort_code != lpp_pkg::AB_NONE ? lpp_pkg::CMD_ABORT :
                    is_dl ? lpp_pkg::CMD_DL_ACK : lpp_pkg::CMD_UL4;
  assign resp_val = abort_code != lpp_pkg::AB_NONE ? abort_code :
                    is_dl ? 32'h0000_0000 : rd_val;
  assign sdo_frame = '{id:   lpp_pkg::COB_SDO_TX + {4'h0, id_s2},
                       dlc:  lpp_pkg::DLC_SDO,
                       data: {resp_val, rx_sub, rx_idx, resp_cmd}};
  assign pdo_frame = '{id:   lpp_pkg::COB_TPDO1 + {4'h0, id_s2},
                       dlc:  lpp_pkg::DLC_PDO,
                       data: {32'h0000_0000, position}};
  assign tx_valid  = state != lpp_pkg::TX_IDLE;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state    <= lpp_pkg::TX_IDLE;
      tx_frame <= '0;
    end else if (ce) begin
      case (state)
        lpp_pkg::TX_IDLE: begin
          if (sdo_load) begin
            state    <= lpp_pkg::TX_SDO;
            tx_frame <= sdo_frame;
          end else if (pdo_load) begin
            state    <= lpp_pkg::TX_PDO;
            tx_frame <= pdo_frame;
          end
        end
        default: begin
          if (tx_ready) begin
            state <= lpp_pkg::TX_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  a_range_alias: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    wr_ok && is_range |=> range_reg == $past(rx_val))
    else $error("range object write not shared");

  a_range_refuse: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    rx_take && is_sdo && is_dl && is_range && !scaling_on
      |=> $stable(range_reg) && tx_frame.data[7:0] == lpp_pkg::CMD_ABORT)
    else $error("range write accepted with scaling off");

  a_reset_values: assert property (@(posedge clk_sys)
    $rose(resetn) |-> range_reg == lpp_pkg::RANGE_RST
      && preset == lpp_pkg::PRESET_RST
      && offset == lpp_pkg::OFFSET_RST)
    else $error("objects not at reset values");

  a_preset_capture: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    wr_ok && rx_idx == lpp_pkg::IDX_PRESET
      |=> preset == $past(rx_val) && offset == $past(read_folded))
    else $error("preset write did not capture offset");

  a_sdo_ack: assert property (@(posedge clk_sys) disable iff (!resetn)
    wr_ok |=> tx_valid && state == lpp_pkg::TX_SDO
      && tx_frame.id == lpp_pkg::COB_SDO_TX + {4'h0, id_s2}
      && tx_frame.data[7:0] == lpp_pkg::CMD_DL_ACK)
    else $error("download not confirmed");

  a_pos_readonly: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    rx_take && is_sdo && is_dl && rx_idx == lpp_pkg::IDX_POS
      && rx_sub == lpp_pkg::SUB_ZERO
      |=> tx_frame.data[7:0] == lpp_pkg::CMD_ABORT
      && tx_frame.data[63:32] == lpp_pkg::AB_RO)
    else $error("position object accepted a write");

  a_pdo_sync: assert property (@(posedge clk_sys) disable iff (!resetn)
    sync_due |=> pdo_pend || state == lpp_pkg::TX_PDO)
    else $error("sync did not schedule a position pdo");

  a_pdo_frame: assert property (@(posedge clk_sys) disable iff (!resetn)
    pdo_load |=> state == lpp_pkg::TX_PDO
      && tx_frame.data[31:0] == $past(position)
      && tx_frame.dlc == lpp_pkg::DLC_PDO)
    else $error("pdo frame does not carry position");

endmodule

/* File: verif/lpp_master_model.sv */
// lpp_master_model: bus master on the frame ports of the position node
// assumes clk_sys shared with the node; one frame in flight at a time
`timescale 1ns/100ps
module lpp_master_model (
  // clock and strap
  input  wire logic                clk_sys,
  input  wire logic [6:0]          node_id,
  // frames to the node
  output lpp_pkg::lpp_frame_t      rx_frame,
  output logic                     rx_valid,
  input  wire logic                rx_ready,
  // frames from the node
  input  wire lpp_pkg::lpp_frame_t tx_frame,
  input  wire logic                tx_valid,
  output logic                     tx_ready
);
  localparam logic [31:0] STEP_NM = 32'h0000_1388; // physical step in nm

  logic        scal;
  logic [31:0] rng;
  logic [31:0] lim;

  initial begin
    rx_frame = '0;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
    scal     = 1'b0;
    rng      = lpp_pkg::RANGE_RST;
  end

  ////////////////////////////////////////////////////////////////////////////
  // offer one frame and hold it until the node takes it or 50 cycles pass
  task automatic send(input lpp_pkg::lpp_frame_t f, output bit ok);
    int n;
    ok = 1'b0;
    @(posedge clk_sys);
    rx_frame <= f;
    rx_valid <= 1'b1;
    for (n = 0; n < 50 && !ok; n++) begin
      @(posedge clk_sys);
      ok = (rx_ready === 1'b1);
    end
    rx_valid <= 1'b0;
    // released lines show no stale frame
    rx_frame <= ~f;
  endtask

  // wait for an answer, stall a while, then accept it
  task automatic take(input int stall, output lpp_pkg::lpp_frame_t f,
                      output bit ok);
    int n;
    ok = 1'b0;
    for (n = 0; n < 20000 && !ok; n++) begin
      @(posedge clk_sys);
      ok = (tx_valid === 1'b1);
    end
    repeat (stall) @(posedge clk_sys);
    tx_ready <= 1'b1;
    @(posedge clk_sys);
    f = tx_frame;
    tx_ready <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // expedited transfer; preset kept below the active range
  task automatic sdo(input logic [7:0] c, input logic [15:0] i,
                     input logic [31:0] v, input int stall,
                     output lpp_pkg::lpp_frame_t r, output bit ok);
    lpp_pkg::lpp_frame_t f;
    bit                  ok_tx;
    if (c == lpp_pkg::CMD_DL4 && i == lpp_pkg::IDX_OPPAR) scal = v[2];
    if (c == lpp_pkg::CMD_DL4 && i == lpp_pkg::IDX_RANGE_A && scal) rng = v;
    lim = scal ? rng : lpp_pkg::RANGE_RST;
    if (c == lpp_pkg::CMD_DL4 && i == lpp_pkg::IDX_PRESET && v >= lim) begin
      v = lim - 32'h1;
    end
    // scaling changes are followed by a new preset from the bench
    f.id   = lpp_pkg::COB_SDO_RX + {4'h0, node_id};
    f.dlc  = lpp_pkg::DLC_SDO;
    f.data = {v, lpp_pkg::SUB_ZERO, i, c};
    send(f, ok_tx);
    take(stall, r, ok);
    ok = ok && ok_tx;
  endtask

  // sync object, then the position frame that it triggers
  task automatic sync_pdo(output lpp_pkg::lpp_frame_t r, output bit ok);
    lpp_pkg::lpp_frame_t f;
    bit                  ok_tx;
    f.id   = lpp_pkg::COB_SYNC;
    f.dlc  = 4'h0;
    f.data = 64'h0;
    send(f, ok_tx);
    take(0, r, ok);
    ok = ok && ok_tx;
  endtask

  // position in nanometres, step size picked by the scaling state
  function automatic logic [63:0] to_nm(input logic [31:0] p,
                                        input logic [31:0] custom);
    logic [31:0] s;
    s = scal ? custom : STEP_NM;
    return {32'h0, p} * {32'h0, s};
  endfunction
endmodule

/* File: verif/lpp_position_node_tb_top.sv */
// lpp_position_node_tb_top: object, preset and position frame tests
// assumes the master model on the frame ports and a steady sensor input
`timescale 1ns/100ps
module lpp_position_node_tb_top;
  logic                clk_sys;
  logic                resetn;
  logic                ce;
  logic [6:0]          node_id;
  logic [31:0]         raw_pos;
  lpp_pkg::lpp_frame_t rx_frame;
  logic                rx_valid;
  logic                rx_ready;
  lpp_pkg::lpp_frame_t tx_frame;
  logic                tx_valid;
  logic                tx_ready;
  logic                scaling_on;
  logic [31:0]         position;
  lpp_pkg::lpp_frame_t r;
  logic [31:0]         v;
  logic [31:0]         pre;
  logic [31:0]         off;
  logic [31:0]         rng;
  logic [10:0]         nid;
  bit                  hs_ok;
  int                  error_cnt;
  int                  n_compared;

  initial clk_sys = 1'b0;
  always #50 clk_sys = ~clk_sys;

  lpp_position_node #(.CYC_PER_MS(8)) u_lpp_position_node (
    .clk_sys(clk_sys), .resetn(resetn), .ce(ce), .node_id(node_id),
    .raw_pos(raw_pos), .rx_frame(rx_frame), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .tx_frame(tx_frame), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .scaling_on(scaling_on), .position(position));

  lpp_master_model u_lpp_master_model (
    .clk_sys(clk_sys), .node_id(node_id), .rx_frame(rx_frame),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_frame(tx_frame),
    .tx_valid(tx_valid), .tx_ready(tx_ready));

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [78:0] seen, input logic [78:0] exp,
                       input string m);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t %s: got %h want %h", $time, m, seen, exp);
    end
  endtask

  // a handshake that ran out of time ends the run as a mismatch
  task automatic need(input bit ok);
    if (!ok) begin
      error_cnt++;
      $display("BAD %0t handshake timeout", $time);
      end_sim();
    end
  endtask

  task automatic sdo(input logic [7:0] c, input logic [15:0] i,
                     input logic [31:0] d, input int st);
    bit ok;
    u_lpp_master_model.sdo(c, i, d, st, r, ok);
    need(ok);
  endtask

  task automatic dl(input logic [15:0] i, input logic [31:0] d);
    sdo(lpp_pkg::CMD_DL4, i, d, 0);
    check({r.id, r.data[7:0]}, {nid, lpp_pkg::CMD_DL_ACK}, "ack");
  endtask

  task automatic ul(input logic [15:0] i);
    sdo(lpp_pkg::CMD_UL_REQ, i, 32'h0, 0);
    v = (r.data[7:0] === lpp_pkg::CMD_UL4) ? r.data[63:32] : 'x;
  endtask

  task automatic abort_chk(input logic [15:0] i, input logic [31:0] code);
    sdo(lpp_pkg::CMD_DL4, i, 32'h100, 0);
    check({r.data[63:32], r.data[7:0]}, {code, lpp_pkg::CMD_ABORT},
          "abort");
  endtask

  // new sensor value, then time to pass sync stages and the fold
  task automatic setpos(input logic [31:0] p);
    @(posedge clk_sys);
    raw_pos <= p;
    repeat (8) @(posedge clk_sys);
    v = (p % rng + pre + rng - off) % rng;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    error_cnt  = 0;
    n_compared = 0;
    resetn     = 1'b0;
    ce         = 1'b1;
    node_id    = 7'h05;
    raw_pos    = 32'h0;
    pre        = 32'h0;
    off        = 32'h0;
    rng        = lpp_pkg::RANGE_RST;
    nid        = lpp_pkg::COB_SDO_TX + 11'h05;
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    ul(lpp_pkg::IDX_RANGE);
    check(v, lpp_pkg::RANGE_RST, "range reset");
    ul(lpp_pkg::IDX_RANGE_A);
    check(v, lpp_pkg::RANGE_RST, "alias reset");
    ul(lpp_pkg::IDX_PRESET);
    check(v, lpp_pkg::PRESET_RST, "preset reset");
    setpos(32'd1234);
    check(position, 32'd1234, "no preset");
    abort_chk(lpp_pkg::IDX_RANGE, lpp_pkg::AB_STATE);
    dl(lpp_pkg::IDX_OPPAR, 32'h4);
    check(scaling_on, 1'b1, "scaling on");
    dl(lpp_pkg::IDX_RANGE_A, 32'h0001_0000);
    rng = 32'h0001_0000;
    ul(lpp_pkg::IDX_RANGE);
    check(v, 32'h0001_0000, "shared range");
    sdo(lpp_pkg::CMD_DL4, lpp_pkg::IDX_RANGE, 32'h0003_0000, 0);
    check(r.data[63:32], lpp_pkg::AB_VALUE, "range bound");
    ul(lpp_pkg::IDX_RANGE_A);
    check(v, 32'h0001_0000, "range kept");
    abort_chk(16'h6100, lpp_pkg::AB_NO_OBJ);
    setpos(32'd1000);
    sdo(lpp_pkg::CMD_DL4, lpp_pkg::IDX_PRESET, 32'd50, 3);
    check(r, {nid, lpp_pkg::DLC_SDO, 64'h0000_0000_0060_0360}, "conf");
    pre = 32'd50;
    off = 32'd1000;
    setpos(32'd1000);
    check(position, v, "preset point");
    ul(lpp_pkg::IDX_OFFSET);
    check(v, 32'd1000, "offset");
    ul(lpp_pkg::IDX_PRESET);
    check(v, 32'd50, "preset rw");
    setpos(32'd1001);
    check(position, v, "step up");
    setpos(32'd950);
    check(position, v, "zero");
    setpos(32'd949);
    check(position, v, "wrap");
    ul(lpp_pkg::IDX_POS);
    check(v, 32'h0000_ffff, "position object");
    abort_chk(lpp_pkg::IDX_POS, lpp_pkg::AB_RO);
    u_lpp_master_model.sync_pdo(r, hs_ok);
    need(hs_ok);
    check({r.id, r.dlc, r.data[31:0]},
          {lpp_pkg::COB_TPDO1 + 11'h05, lpp_pkg::DLC_PDO, 32'h0000_ffff},
          "sync frame");
    dl(lpp_pkg::IDX_OPPAR, 32'h0);
    check(scaling_on, 1'b0, "scaling off");
    rng = lpp_pkg::RANGE_RST;
    setpos(32'd5);
    dl(lpp_pkg::IDX_PRESET, 32'd131071);
    pre = 32'd131071;
    off = 32'd5;
    setpos(32'd6);
    check(position, v, "physical wrap");
    setpos(32'd4);
    check(position, v, "physical back");
    check(u_lpp_master_model.to_nm(position, 32'h0),
          64'd655350000, "nm");
    dl(lpp_pkg::IDX_CYCLE, 32'h1);
    u_lpp_master_model.take(2, r, hs_ok);
    need(hs_ok);
    check({r.id, r.data[31:0]}, {lpp_pkg::COB_TPDO1 + 11'h05, 32'd131070},
          "cyclic frame");
    end_sim();
  end
endmodule
